/* File: core/pcm_pkg.sv */
/*
  Package of the position coordinate manager: register map, field
  positions, reset values, gear multipliers and the pin carrier struct.
  Assumes a 32-bit AHB-Lite register bus with one word per register.
*/
package pcm_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] PCM_A_CTRL   = 8'h00; // Wrap, alarm and overtravel enables
  localparam logic [7:0] PCM_A_RANGE  = 8'h04; // Wrap range, steps
  localparam logic [7:0] PCM_A_GEAR_A = 8'h08;
  localparam logic [7:0] PCM_A_GEAR_B = 8'h0C;
  localparam logic [7:0] PCM_A_CMD    = 8'h10; // Write-only command strobes
  localparam logic [7:0] PCM_A_STAT   = 8'h14;
  localparam logic [7:0] PCM_A_POS    = 8'h18;
  localparam logic [7:0] PCM_A_MROT   = 8'h1C;

  // ==========================================================
  // Field positions
  localparam int PCM_B_WRAP_EN  = 0; // CTRL
  localparam int PCM_B_HOME_AEN = 1; // CTRL
  localparam int PCM_B_SOT_EN   = 2; // CTRL
  localparam int PCM_B_CFG_EXEC = 0; // CMD
  localparam int PCM_B_HOME_CLR = 1; // CMD

  // ==========================================================
  // Widths and reset values
  localparam int             PCM_POS_W     = 24;
  localparam int             PCM_RANGE_W   = 23;
  localparam int             PCM_GEAR_W    = 16;
  localparam int             PCM_MROT_W    = 16;
  localparam logic [2:0]     PCM_CTRL_RST  = 3'h0; // Wrap off, alarm off, overtravel off
  localparam logic [22:0]    PCM_RANGE_RST = 23'h0003E8; // 1000 steps
  localparam logic [15:0]    PCM_GEAR_RST  = 16'h0001;
  localparam logic [9:0]     PCM_GEAR_MULB = 10'h3E8; // 1000
  localparam logic [5:0]     PCM_GEAR_MULA = 6'h32;   // 50
  localparam logic [PCM_POS_W-1:0] PCM_STEPS_REV = 24'h0003E8; // Steps per rotation

  // ==========================================================
  // Modulo engine widths and boot delay
  localparam int         PCM_NUM_W   = 48;
  localparam int         PCM_DEN_W   = 32;
  localparam logic [1:0] PCM_BOOT_CAP = 2'h2; // Strap capture once synchronisers settle

  // ==========================================================
  // Control pins from the host, all asynchronous to hclk
  typedef struct packed {
    logic       start;
    logic       sequential_start_input;
    logic [5:0] direct_data_select_input; // _first is bit 0, _last is bit 5
    logic       preset;
    logic       home_done;
    logic       position_alarm_clear_input;
    logic       abs_error;
  } pcm_pins_t;

endpackage : pcm_pkg

/* File: core/pcm_mod_check.sv */
/*
  Serial modulo engine: tells whether num is an exact multiple of den.
  One quotient bit per clock; a zero divisor reports not-integer.
  Assumes start is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pcm_mod_check
  import pcm_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 start,
  input  wire logic [PCM_NUM_W-1:0] num,
  input  wire logic [PCM_DEN_W-1:0] den,
  output var  logic                 done,
  output var  logic                 is_int
);

  logic [PCM_NUM_W-1:0] shreg;
  logic [PCM_DEN_W-1:0] rem;
  logic [PCM_DEN_W-1:0] dsr;
  logic [5:0]           cnt;
  logic                 busy;
  logic [PCM_DEN_W:0]   rem_sh;
  logic                 fits;

  // ==========================================================
  // Shift-subtract step
  assign rem_sh = {rem, shreg[PCM_NUM_W-1]};
  assign fits   = rem_sh >= {1'b0, dsr};

  // Restoring division, remainder only; a long loop saves a wide divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shreg  <= '0;
      rem    <= '0;
      dsr    <= '0;
      cnt    <= 6'h00;
      busy   <= 1'b0;
      done   <= 1'b0;
      is_int <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        shreg <= num;
        dsr   <= den;
        rem   <= '0;
        cnt   <= 6'h00;
        busy  <= 1'b1;
      end else if (busy) begin
        shreg <= {shreg[PCM_NUM_W-2:0], 1'b0};
        rem   <= fits ? PCM_DEN_W'(rem_sh - {1'b0, dsr}) : rem_sh[PCM_DEN_W-1:0];
        cnt   <= cnt + 6'h01;
        if (cnt == 6'(PCM_NUM_W - 1)) begin
          busy   <= 1'b0;
          done   <= 1'b1;
          is_int <= (dsr != '0) && (fits ? (rem_sh == {1'b0, dsr}) : (rem_sh == '0));
        end
      end
    end
  end

endmodule : pcm_mod_check

`default_nettype wire

/* File: core/pcm_core.sv */
/*
  Position coordinate manager: command position, origin state, missing-origin
  alarm, absolute position error handling and wrap function with its
  gear consistency check, behind an AHB-Lite register slave.
  Assumes host pins are asynchronous and step_pulse/step_dir come from the
  pulse generator on hclk. The battery domain supplies abs_backup_enable and
  backup_origin_kept, both read once after reset.
*/
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
// Notes on behaviour
// - Backup off: origin set on return-to-home completion or preset input.
// - Backup on: stored origin survives power loss, restored at power-up.
// - Absolute position error clears the origin-valid state.
// - Missing-origin alarm enable bit: 0 off, 1 on, reset value 0.
// - Enabled, no origin: start, sequential start or data select raises alarm, blocks start.
// - Wrap on: position past range resets position and rotation count to zero.
// - Wrap on: command position stays within zero to range minus one.
// - Wrap enable bit: 0 off, 1 on, reset value 0.
// - Wrap range accepts 1 to 8,388,607 steps, reset value 1000.
// - Wrap on forces software overtravel off regardless of its enable.
// - Wrap on: warning unless both gear quotients are integers.
// - Warning at power-up or configuration execute escalates to wrap alarm.
// - Software overtravel acts only once the origin is established.
`timescale 1ns/1ps
`default_nettype none

module pcm_core
  import pcm_pkg::*;
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output var  logic                   hreadyout,
  output var  logic [31:0]            hrdata,
  output var  logic                   hresp,
  input  wire pcm_pins_t              pins,
  input  wire logic                   abs_backup_enable,
  input  wire logic                   backup_origin_kept,
  input  wire logic                   step_pulse,
  input  wire logic                   step_dir,
  output var  logic                   origin_valid,
  output var  logic                   home_alarm,
  output var  logic                   abs_alarm,
  output var  logic                   wrap_warning,
  output var  logic                   wrap_alarm,
  output var  logic                   soft_ot_active,
  output var  logic                   start_accept,
  output var  logic [PCM_POS_W-1:0]   cmd_position,
  output var  logic [PCM_MROT_W-1:0]  multi_rotation
);

  // ==========================================================
  // Pin synchronisers
  localparam int SYW = $bits(pcm_pins_t) + 2;

  logic [SYW-1:0] sy1;
  logic [SYW-1:0] sy2;
  logic [SYW-1:0] sy3;
  pcm_pins_t      pin_s;
  pcm_pins_t      pin_d;
  logic           sy_bk_en;
  logic           sy_bk_kept;

  // Two stages before any use; the third stage only feeds edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
    end else begin
      sy1 <= {pins, abs_backup_enable, backup_origin_kept};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end

  assign pin_s      = pcm_pins_t'(sy2[SYW-1:2]);
  assign pin_d      = pcm_pins_t'(sy3[SYW-1:2]);
  assign sy_bk_en   = sy2[1];
  assign sy_bk_kept = sy2[0];

  // Rising edges of the host pins
  logic rise_start;
  logic rise_preset;
  logic rise_home;
  logic rise_clr;
  logic rise_err;

  assign rise_start  = (pin_s.start & ~pin_d.start)
                     | (pin_s.sequential_start_input & ~pin_d.sequential_start_input)
                     | (|(pin_s.direct_data_select_input & ~pin_d.direct_data_select_input));
  assign rise_preset = pin_s.preset & ~pin_d.preset;
  assign rise_home   = pin_s.home_done & ~pin_d.home_done;
  assign rise_clr    = pin_s.position_alarm_clear_input & ~pin_d.position_alarm_clear_input;
  assign rise_err    = pin_s.abs_error & ~pin_d.abs_error;

  // ==========================================================
  // AHB-Lite slave, zero wait states, always OKAY
  logic        ap_wr;
  logic        ap_rd;
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic [31:0] rd_mux;

  assign ap_wr = hsel & hready & htrans[1] & hwrite;
  assign ap_rd = hsel & hready & htrans[1] & ~hwrite;

  // Address phase is held for the write data phase; reads are muxed early
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr     <= 1'b0;
      dp_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_wr   <= ap_wr;
      dp_addr <= haddr[7:0];
      hrdata  <= ap_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Configuration registers
  logic [2:0]             ctrl;
  logic [PCM_RANGE_W-1:0] wrap_range;
  logic [PCM_GEAR_W-1:0]  gear_a;
  logic [PCM_GEAR_W-1:0]  gear_b;
  logic                   wr_ctrl;
  logic                   wr_range;
  logic                   wr_gear_a;
  logic                   wr_gear_b;
  logic                   wr_cmd;
  logic                   cfg_exec;
  logic                   home_clr;
  logic                   wrap_en;

  assign wr_ctrl   = dp_wr && dp_addr == PCM_A_CTRL;
  assign wr_range  = dp_wr && dp_addr == PCM_A_RANGE && hwdata[PCM_RANGE_W-1:0] != '0;
  assign wr_gear_a = dp_wr && dp_addr == PCM_A_GEAR_A;
  assign wr_gear_b = dp_wr && dp_addr == PCM_A_GEAR_B;
  assign wr_cmd    = dp_wr && dp_addr == PCM_A_CMD;
  assign cfg_exec  = wr_cmd & hwdata[PCM_B_CFG_EXEC];
  assign home_clr  = wr_cmd & hwdata[PCM_B_HOME_CLR];
  assign wrap_en   = ctrl[PCM_B_WRAP_EN];

  // A zero range is refused; the field width caps it at 8,388,607
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl       <= PCM_CTRL_RST;
      wrap_range <= PCM_RANGE_RST;
      gear_a     <= PCM_GEAR_RST;
      gear_b     <= PCM_GEAR_RST;
    end else begin
      if (wr_ctrl)   ctrl       <= hwdata[2:0];
      if (wr_range)  wrap_range <= hwdata[PCM_RANGE_W-1:0];
      if (wr_gear_a) gear_a     <= hwdata[PCM_GEAR_W-1:0];
      if (wr_gear_b) gear_b     <= hwdata[PCM_GEAR_W-1:0];
    end
  end

  // ==========================================================
  // Boot: capture the battery-domain straps after release
  logic [1:0] boot_cnt;
  logic       boot_cap;
  logic       backup_en;

  assign boot_cap = boot_cnt == PCM_BOOT_CAP;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_cnt  <= 2'h0;
      backup_en <= 1'b0;
    end else begin
      if (boot_cnt != 2'h3) boot_cnt <= boot_cnt + 2'h1;
      if (boot_cap) backup_en <= sy_bk_en;
    end
  end

  // ==========================================================
  // Origin, absolute error and missing-origin alarm
  logic set_origin;
  logic blocked;

  // Origin requests are ignored until the error is cleared by the host
  assign set_origin = (rise_home | rise_preset) & ~abs_alarm;
  assign blocked    = ctrl[PCM_B_HOME_AEN] & ~origin_valid & rise_start;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      origin_valid <= 1'b0;
      abs_alarm    <= 1'b0;
      home_alarm   <= 1'b0;
      start_accept <= 1'b0;
    end else begin
      if (rise_err)
        origin_valid <= 1'b0;
      else if (set_origin)
        origin_valid <= 1'b1;
      else if (boot_cap)
        origin_valid <= sy_bk_en & sy_bk_kept;
      abs_alarm    <= rise_err | (abs_alarm & ~rise_clr);   // Error wins
      home_alarm   <= blocked | (home_alarm & ~home_clr);   // Set wins
      start_accept <= rise_start & ~blocked;
    end
  end

  // ==========================================================
  // Command position and rotation count
  logic [PCM_POS_W-1:0] rot_step;
  logic [PCM_POS_W-1:0] range_ext;
  logic [PCM_POS_W-1:0] pos_inc;
  logic [PCM_POS_W-1:0] pos_dec;
  logic                 wrap_out;
  logic [PCM_POS_W-1:0] wrap_top;

  assign range_ext = {1'b0, wrap_range};
  assign wrap_top  = range_ext - 24'h000001;
  assign pos_inc   = cmd_position + 24'h000001;
  assign pos_dec   = cmd_position - 24'h000001;
  // Position outside 0..range-1 when wrap turns on is pulled to zero
  assign wrap_out  = wrap_en & (cmd_position[PCM_POS_W-1] | cmd_position >= range_ext);

  // Upward wrap also clears the rotation count so unidirectional turning never overflows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_position   <= '0;
      multi_rotation <= '0;
      rot_step       <= '0;
    end else if (set_origin | wrap_out) begin
      cmd_position   <= '0;
      multi_rotation <= '0;
      rot_step       <= '0;
    end else if (step_pulse && step_dir) begin
      if (wrap_en && pos_inc >= range_ext) begin
        cmd_position   <= '0;
        multi_rotation <= '0;
        rot_step       <= '0;
      end else begin
        cmd_position <= pos_inc;
        if (rot_step == PCM_STEPS_REV - 24'h000001) begin
          rot_step       <= '0;
          multi_rotation <= multi_rotation + 16'h0001;
        end else begin
          rot_step <= rot_step + 24'h000001;
        end
      end
    end else if (step_pulse) begin
      if (wrap_en && cmd_position == '0) begin
        // Rotation split follows range-1; a constant divider, but the count stays true
        cmd_position   <= wrap_top;
        rot_step       <= wrap_top % PCM_STEPS_REV;
        multi_rotation <= PCM_MROT_W'(wrap_top / PCM_STEPS_REV);
      end else begin
        cmd_position <= pos_dec;
        if (rot_step == '0) begin
          rot_step       <= PCM_STEPS_REV - 24'h000001;
          multi_rotation <= multi_rotation - 16'h0001;
        end else begin
          rot_step <= rot_step - 24'h000001;
        end
      end
    end
  end

  // Overtravel limit checking is gated here, the limit logic lives elsewhere
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      soft_ot_active <= 1'b0;
    else
      soft_ot_active <= ctrl[PCM_B_SOT_EN] & ~wrap_en & origin_valid;
  end

  // ==========================================================
  // Wrap setting check
  logic [PCM_NUM_W-1:0] num1;
  logic [PCM_NUM_W-1:0] num2;
  logic [PCM_DEN_W-1:0] den1;
  logic [PCM_DEN_W-1:0] den2;
  logic                 chk_req;
  logic                 chk_go;
  logic                 esc_pend;
  logic                 done1;
  logic                 done2;
  logic                 int1;
  logic                 int2;
  logic                 c1_ok;
  logic                 c2_ok;
  logic                 cfg_change;

  // Condition 1: B*1000 / (A*50); condition 2: range*A*50 / (B*1000)
  assign num1 = PCM_NUM_W'(gear_b) * PCM_NUM_W'(PCM_GEAR_MULB);
  assign den1 = PCM_DEN_W'(gear_a) * PCM_DEN_W'(PCM_GEAR_MULA);
  assign num2 = PCM_NUM_W'(wrap_range) * PCM_NUM_W'(gear_a) * PCM_NUM_W'(PCM_GEAR_MULA);
  assign den2 = PCM_DEN_W'(gear_b) * PCM_DEN_W'(PCM_GEAR_MULB);
  assign cfg_change = wr_ctrl | wr_range | wr_gear_a | wr_gear_b;

  // Both engines run in lockstep, so done1 marks the end of both
  assign chk_go = chk_req & ~cfg_change;

  pcm_mod_check u_cond1 (
    .hclk (hclk), .hresetn (hresetn), .start (chk_go),
    .num (num1), .den (den1), .done (done1), .is_int (int1)
  );

  pcm_mod_check u_cond2 (
    .hclk (hclk), .hresetn (hresetn), .start (chk_go),
    .num (num2), .den (den2), .done (done2), .is_int (int2)
  );

  // A change during a check restarts both engines on the next idle cycle, abandoning the check in progress
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chk_req      <= 1'b1;  // Power-up check
      esc_pend     <= 1'b1;
      c1_ok        <= 1'b1;
      c2_ok        <= 1'b1;
      wrap_warning <= 1'b0;
      wrap_alarm   <= 1'b0;
    end else begin
      if (cfg_change | cfg_exec)
        chk_req <= 1'b1;
      else if (chk_go)
        chk_req <= 1'b0;
      if (cfg_exec)
        esc_pend <= 1'b1;
      else if (done1 & ~chk_req)
        esc_pend <= 1'b0;
      if (done1 & done2) begin
        c1_ok <= int1;
        c2_ok <= int2;
      end
      wrap_warning <= wrap_en & ~(c1_ok & c2_ok);
      if (done1 && !chk_req && esc_pend && wrap_en && !(int1 && int2))
        wrap_alarm <= 1'b1;
    end
  end

  // ==========================================================
  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    unique case (haddr[7:0])
      PCM_A_CTRL:   rd_mux = {29'h0000_0000, ctrl};
      PCM_A_RANGE:  rd_mux = {9'h000, wrap_range};
      PCM_A_GEAR_A: rd_mux = {16'h0000, gear_a};
      PCM_A_GEAR_B: rd_mux = {16'h0000, gear_b};
      PCM_A_STAT:   rd_mux = {24'h000000, chk_req, backup_en, soft_ot_active,
                              wrap_alarm, wrap_warning, abs_alarm, home_alarm, origin_valid};
      PCM_A_POS:    rd_mux = {{8{cmd_position[PCM_POS_W-1]}}, cmd_position};
      PCM_A_MROT:   rd_mux = {{16{multi_rotation[PCM_MROT_W-1]}}, multi_rotation};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

endmodule : pcm_core

`default_nettype wire

/* File: test/pcm_host_model.sv */
/*
  Host controller model: drives the control pins of the coordinate manager.
  Assumes pins are sampled on hclk by a two-stage synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Pin driver
module pcm_host_model
  import pcm_pkg::*;
(
  input  wire logic      hclk,
  output var  pcm_pins_t pins
);
  logic [$bits(pcm_pins_t)-1:0] lvl;

  assign pins = pcm_pins_t'(lvl);
  initial lvl = '0;

  // Four cycles each way, longer than the synchroniser needs
  task automatic pulse(input int idx);
    lvl[idx] <= 1'b1;
    repeat (4) @(posedge hclk);
    lvl[idx] <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : pulse

  // Alarm clear first: an origin request under alarm is ignored
  task automatic recover(input int org_idx);
    pulse(1);
    pulse(org_idx);
  endtask : recover
endmodule : pcm_host_model
`default_nettype wire

/* File: test/pcm_core_props.sv */
/*
  Checker of the coordinate manager ports.
  Assumes one clock hclk and the active-low asynchronous reset hresetn.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port checker
module pcm_core_props
  import pcm_pkg::*;
(
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  step_pulse,
  input wire logic                  step_dir,
  input wire logic                  origin_valid,
  input wire logic                  home_alarm,
  input wire logic                  abs_alarm,
  input wire logic                  wrap_warning,
  input wire logic                  wrap_alarm,
  input wire logic                  soft_ot_active,
  input wire logic                  start_accept,
  input wire logic [PCM_POS_W-1:0]  cmd_position,
  input wire logic [PCM_MROT_W-1:0] multi_rotation
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Zero wait states, never an error response
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_ot_needs_origin: assert property (soft_ot_active |-> $past(origin_valid))
    else $error("overtravel active without origin");
  a_abs_drops_origin: assert property (abs_alarm && $past(abs_alarm) |-> !origin_valid)
    else $error("origin valid under position error");
  a_home_alarm_cause: assert property ($rose(home_alarm) |-> !$past(origin_valid))
    else $error("missing-origin alarm with origin set");
  a_accept_pulse: assert property (start_accept |=> !start_accept)
    else $error("start accept longer than one cycle");
  a_step_up: assert property (step_pulse && step_dir |=>
      cmd_position == $past(cmd_position) + 1'b1 || cmd_position == '0)
    else $error("up step did not advance or wrap");
  a_wrap_rot_zero: assert property ($past(step_pulse) && $past(step_dir) &&
      cmd_position == '0 && $past(cmd_position) != '0 |-> multi_rotation == '0)
    else $error("rotation count kept across wrap");
  a_alarm_needs_warn: assert property ($rose(wrap_alarm) |->
      wrap_warning || $past(wrap_warning))
    else $error("wrap alarm without warning");
  a_alarm_sticky: assert property ($past(wrap_alarm) |-> wrap_alarm)
    else $error("wrap alarm dropped");
  a_origin_zeroes: assert property ($rose(origin_valid) |-> cmd_position == '0)
    else $error("origin set away from zero");

  // Main scenarios reached
  c_accept: cover property (start_accept);
  c_home_alarm: cover property ($rose(home_alarm));
  c_wrap_alarm: cover property ($rose(wrap_alarm));
endmodule : pcm_core_props

bind pcm_core pcm_core_props u_props (.hclk, .hresetn, .hreadyout, .hresp, .step_pulse,
  .step_dir, .origin_valid, .home_alarm, .abs_alarm, .wrap_warning, .wrap_alarm,
  .soft_ot_active, .start_accept, .cmd_position, .multi_rotation);
`default_nettype wire

/* File: test/pcm_core_tb.sv */
/*
  Self-checking bench of pcm_core: AHB-Lite master tasks, host pins, steps.
  Assumes the host model drives pins and the checker binds itself.
*/
`timescale 1ns/1ps
`default_nettype none

module pcm_core_tb
  import pcm_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, abs_backup_enable, backup_origin_kept;
  logic        step_pulse, step_dir, dir;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, rd;
  wire logic   hready, hreadyout, hresp, origin_valid, home_alarm, abs_alarm;
  wire logic   wrap_warning, wrap_alarm, soft_ot_active, start_accept;
  wire logic [31:0]           hrdata;
  wire logic [PCM_POS_W-1:0]  cmd_position;
  wire logic [PCM_MROT_W-1:0] multi_rotation;
  wire pcm_pins_t             pins;
  int n_mismatch, tests_run, n_acc, seed, r, p, i;

  // ==========================================================
  // Design, host and clock
  assign hready = hreadyout;
  pcm_core DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .pins, .abs_backup_enable, .backup_origin_kept,
    .step_pulse, .step_dir, .origin_valid, .home_alarm, .abs_alarm, .wrap_warning,
    .wrap_alarm, .soft_ot_active, .start_accept, .cmd_position, .multi_rotation);
  pcm_host_model host (.hclk, .pins);
  always #5 hclk = ~hclk;
  // Accept pulses counted where they stand
  always @(posedge hclk) if (start_accept === 1'b1) n_acc++;

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    #1;
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Only the watchdog ends a stalled wait
  task automatic wait_ready;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask : wait_ready

  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(what, exp, rd);
  endtask : rdchk

  task automatic step(input logic up);
    step_pulse <= 1'b1;
    step_dir <= up;
    @(posedge hclk);
    step_pulse <= 1'b0;
    @(posedge hclk);
  endtask : step

  // Straps set with reset so they are stable before release
  task automatic do_reset(input logic bk, input logic kept);
    hresetn <= 1'b0;
    abs_backup_enable <= bk;
    backup_origin_kept <= kept;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : do_reset

  function automatic int wrap_step(input int pos, input int rng, input logic up);
    if (up) return (pos + 1 == rng) ? 0 : pos + 1;
    return (pos == 0) ? rng - 1 : pos - 1;
  endfunction : wrap_step

  function automatic logic gear_warn(input int a, input int b, input int rng);
    return ((b * 1000) % (a * 50) != 0) || ((rng * a * 50) % (b * 1000) != 0);
  endfunction : gear_warn

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Scenarios
  initial begin
    {hclk, hresetn, hsel, hwrite, step_pulse, step_dir} = '0;
    {abs_backup_enable, backup_origin_kept, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {n_mismatch, tests_run, n_acc} = '0;
    seed = 25;
    do_reset(1'b0, 1'($random(seed)));
    rdchk("ctrl", PCM_A_CTRL, 32'h0);
    rdchk("hole", 8'h40, 32'h0);
    wr(PCM_A_RANGE, 32'h0);
    rdchk("range", PCM_A_RANGE, 32'h000003E8);
    check("no origin", 1'b0, origin_valid);
    wr(PCM_A_CTRL, 32'h2);
    for (i = 4; i < 12; i++) begin
      host.pulse(i);
      check("home alarm", 1'b1, home_alarm);
      check("blocked", 0, n_acc);
      wr(PCM_A_CMD, 32'h2);
      @(posedge hclk);
      check("alarm clear", 1'b0, home_alarm);
    end
    host.pulse(3);
    check("origin", 1'b1, origin_valid);
    host.pulse(11);
    check("accepted", 1, n_acc);
    check("no alarm", 1'b0, home_alarm);
    r = 5 + ($unsigned($random(seed)) % 16);
    wr(PCM_A_RANGE, r);
    wr(PCM_A_CTRL, 32'h1);
    host.pulse(3);
    p = 0;
    for (i = 0; i < 3 * r; i++) begin
      dir = (i < 2 * r) || ($random(seed) % 2 != 0);
      step(dir);
      p = wrap_step(p, r, dir);
      check("wrap pos", p, cmd_position);
      check("wrap rot", 0, multi_rotation);
    end
    rdchk("pos reg", PCM_A_POS, p);
    wr(PCM_A_CTRL, 32'h5);
    repeat (2) @(posedge hclk);
    check("sot wrap", 1'b0, soft_ot_active);
    wr(PCM_A_CTRL, 32'h4);
    repeat (2) @(posedge hclk);
    check("sot on", 1'b1, soft_ot_active);
    host.pulse(0);
    check("abs alarm", 1'b1, abs_alarm);
    check("origin lost", 1'b0, origin_valid);
    check("sot off", 1'b0, soft_ot_active);
    host.pulse(3);
    check("preset refused", 1'b0, origin_valid);
    host.recover(2);
    check("alarm cleared", 1'b0, abs_alarm);
    check("rehomed", 1'b1, origin_valid);
    do_reset(1'b1, 1'b1);
    check("kept origin", 1'b1, origin_valid);
    do_reset(1'b0, 1'b1);
    check("origin cleared", 1'b0, origin_valid);
    repeat (80) @(posedge hclk);
    wr(PCM_A_CTRL, 32'h1);
    for (i = 0; i < 5; i++) begin
      r = (i == 0) ? 3 : 1 + ($unsigned($random(seed)) % 4);
      p = 1 + ($unsigned($random(seed)) % 4);
      wr(PCM_A_GEAR_A, r);
      wr(PCM_A_GEAR_B, p);
      repeat (80) @(posedge hclk);
      check("warn", gear_warn(r, p, 1000), wrap_warning);
    end
    check("no escalation", 1'b0, wrap_alarm);
    wr(PCM_A_GEAR_A, 32'h3);
    wr(PCM_A_GEAR_B, 32'h1);
    repeat (80) @(posedge hclk);
    wr(PCM_A_CMD, 32'h1);
    repeat (80) @(posedge hclk);
    check("escalated", 1'b1, wrap_alarm);
    tally_and_finish();
  end

  // Hang guard, far beyond the thousand or so cycles the run needs
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : pcm_core_tb
`default_nettype wire
